// ===== rtl/rcd_countdown.sv
// Loadable down counter with a one-cycle done pulse
`timescale 1ns/1ps
module rcd_countdown #(
  parameter int W = 42
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Control
  input wire logic load,
  input wire logic clear,
  input wire logic [W-1:0] start,
  // Status
  output logic done
);

  typedef struct packed {
    logic [W-1:0] count;
    logic done;
  } rcd_cd_state_t;

  rcd_cd_state_t q;
  rcd_cd_state_t next_q;

  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    if (load) begin
      next_q.count = start;
    end else if (clear) begin
      next_q.count = '0;
    end else if (q.count != '0) begin
      next_q.count = q.count - W'(1);
      next_q.done = (q.count == W'(1));
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign done = q.done;

endmodule : rcd_countdown

// ===== rtl/rcd_dispatcher.sv
// Remote command dispatcher: page decode, relays, fences, reports, power
//
// Operation
// - One primary and nine secondary numbers, each secondary a fixed function
// - Number 0 only names the report source; never taken as a command
// - Number 1 requests a position report with current position
// - Number 2 operates port 1 to unlock doors, no acknowledgement
// - Number 3 operates port 2 to disable starter, no acknowledgement
// - Number 4 operates port 2 to re-enable starter, no acknowledgement
// - Number 5 selects fence one, zero to one mile, no reply
// - Number 6 selects fence two, zero to twenty-five miles, no reply
// - Number 7 selects fence three, zero to fifty miles, no reply
// - Number 8 requests a status report
// - Number 9 switches all fences off, no reply
// - Crash sensor input events send an unsolicited report
// - Full power with ignition on; managed mode once ignition is off
// - Leave managed mode after 72 hours or on battery below 8 V
// - Every report is exactly 45 bits
// - Report carries a one-bit identifier: position or status
// - Door unlock drives port 1 high for one five-second pulse
// - Starter disable drives port 2 low, latched
// - Starter enable drives port 2 high, latched
// - Position layout: id, 21-bit latitude, 22-bit longitude, fix flag
`timescale 1ns/1ps
module rcd_dispatcher #(
  parameter logic [rcd_pkg::TMR_W-1:0] DOOR_CYCLES =
    rcd_pkg::TMR_W'(rcd_pkg::DOOR_CYCLES),
  parameter logic [rcd_pkg::TMR_W-1:0] PM_CYCLES =
    rcd_pkg::TMR_W'(rcd_pkg::PM_CYCLES)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Forward channel pages
  input wire rcd_pkg::rcd_page_t page_in,
  // Reverse channel reports
  output rcd_pkg::rcd_report_t report_out,
  input wire logic report_ready,
  // Vehicle inputs
  input wire logic crash_low,
  input wire logic crash_high,
  input wire logic ignition,
  input wire logic battery_low,
  // Vehicle outputs
  output logic door_unlock,
  output logic starter_enable,
  output rcd_pkg::rcd_fence_t fence_sel,
  output logic pm_mode,
  output logic shutdown
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int LON_W_C = rcd_pkg::LON_W;

  typedef struct packed {
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [31:0] lat;
    logic [LON_W_C-1:0] lon;
    logic [31:0] stat_a;
    logic [rcd_pkg::AGE_W-1:0] stat_b;
    logic door;
    logic starter;
    rcd_pkg::rcd_fence_t fence;
    rcd_pkg::rcd_power_t pwr;
    logic pm_mode;
    logic shutdown;
    logic pos_pend;
    logic stat_pend;
    logic low_prev;
    logic high_prev;
    rcd_pkg::rcd_report_t rpt;
    logic [rcd_pkg::TMR_W-1:0] door_len;
  } rcd_state_t;

  rcd_state_t q;
  rcd_state_t next_q;

  logic cmd_ok;
  logic door_cmd;
  logic door_done;
  logic pm_load;
  logic pm_done;
  logic crash_evt;
  logic [2:0] fence_set;
  logic [rcd_pkg::REPORT_W-1:0] pos_bits;
  logic [rcd_pkg::REPORT_W-1:0] stat_bits;
  logic [7:0] rd_sel;

  // ----------------------------------------------------------------
  // Decode and report images
  // ----------------------------------------------------------------
  // Number 0 and anything above 9 fall outside the accepted range
  assign cmd_ok = page_in.valid && page_in.id >= rcd_pkg::ID_POSITION &&
                  page_in.id <= rcd_pkg::ID_FENCE_OFF;
  assign door_cmd = cmd_ok && page_in.id == rcd_pkg::ID_DOOR;
  // Only rising edges report, so a sensor held active sends once
  assign crash_evt = (crash_low && !q.low_prev) ||
                     (crash_high && !q.high_prev);
  assign fence_set = {q.fence == rcd_pkg::FENCE_50MI,
                      q.fence == rcd_pkg::FENCE_25MI,
                      q.fence == rcd_pkg::FENCE_1MI};
  assign pos_bits = {rcd_pkg::MSG_POSITION, q.lat[rcd_pkg::LAT_W-1:0],
                     q.lon, q.lat[rcd_pkg::FIX_BIT]};
  assign stat_bits = {rcd_pkg::MSG_STATUS,
                      q.stat_a[rcd_pkg::BATT_LSB +: 8],
                      q.stat_a[rcd_pkg::RSSI_LSB +: 8],
                      q.stat_a[rcd_pkg::SPEED_LSB +: 6],
                      q.stat_b,
                      q.stat_a[rcd_pkg::GPS_LSB +: 3],
                      fence_set,
                      q.stat_a[rcd_pkg::VIOL_BIT],
                      q.door, q.starter, crash_low, crash_high};
  assign pm_load = q.pwr == rcd_pkg::PWR_FULL && !ignition;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  rcd_countdown #(.W(rcd_pkg::TMR_W)) u_door_tmr (
    .sys_clk(sys_clk),
    .reset(reset),
    .load(door_cmd),
    .clear(1'b0),
    .start(DOOR_CYCLES - rcd_pkg::TMR_W'(1)),
    .done(door_done)
  );

  rcd_countdown #(.W(rcd_pkg::TMR_W)) u_pm_tmr (
    .sys_clk(sys_clk),
    .reset(reset),
    .load(pm_load),
    .clear(ignition),
    .start(PM_CYCLES - rcd_pkg::TMR_W'(1)),
    .done(pm_done)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    rd_sel = hsel && htrans[1] && hready && !hwrite ? haddr : 8'hff;
    next_q.hreadyout = 1'b1;
    next_q.low_prev = crash_low;
    next_q.high_prev = crash_high;
    // Pulse length seen by the checks below
    next_q.door_len = q.door ? q.door_len + rcd_pkg::TMR_W'(1) : '0;
    // Bus: address phase capture, then write in the data phase
    next_q.ap_valid = hsel && htrans[1] && hready;
    next_q.ap_write = hwrite;
    next_q.ap_addr = haddr;
    if (q.ap_valid && q.ap_write) begin
      case (q.ap_addr)
        rcd_pkg::A_POS_LAT: next_q.lat = hwdata;
        rcd_pkg::A_POS_LON: next_q.lon = hwdata[LON_W_C-1:0];
        rcd_pkg::A_STAT_A: next_q.stat_a = hwdata;
        rcd_pkg::A_STAT_B: next_q.stat_b = hwdata[rcd_pkg::AGE_W-1:0];
        default: next_q.lat = q.lat;
      endcase
    end
    // Commands; none of them acknowledges except 1 and 8
    if (cmd_ok) begin
      case (page_in.id)
        rcd_pkg::ID_POSITION: next_q.pos_pend = 1'b1;
        rcd_pkg::ID_DOOR: next_q.door = 1'b1;
        rcd_pkg::ID_STARTER_OFF: next_q.starter = 1'b0;
        rcd_pkg::ID_STARTER_ON: next_q.starter = 1'b1;
        rcd_pkg::ID_FENCE_1: next_q.fence = rcd_pkg::FENCE_1MI;
        rcd_pkg::ID_FENCE_2: next_q.fence = rcd_pkg::FENCE_25MI;
        rcd_pkg::ID_FENCE_3: next_q.fence = rcd_pkg::FENCE_50MI;
        rcd_pkg::ID_STATUS: next_q.stat_pend = 1'b1;
        rcd_pkg::ID_FENCE_OFF: next_q.fence = rcd_pkg::FENCE_OFF;
        default: next_q.door = q.door;
      endcase
    end
    // Pulse ends when the timer runs out, unless just retriggered
    if (door_done && !door_cmd) begin
      next_q.door = 1'b0;
    end
    // Power management
    case (q.pwr)
      rcd_pkg::PWR_FULL: begin
        if (!ignition) next_q.pwr = rcd_pkg::PWR_MANAGED;
      end
      rcd_pkg::PWR_MANAGED: begin
        if (ignition) next_q.pwr = rcd_pkg::PWR_FULL;
        else if (pm_done || battery_low) next_q.pwr = rcd_pkg::PWR_OFF;
      end
      rcd_pkg::PWR_OFF: begin
        if (ignition) next_q.pwr = rcd_pkg::PWR_FULL;
      end
      default: next_q.pwr = rcd_pkg::PWR_FULL;
    endcase
    next_q.pm_mode = next_q.pwr == rcd_pkg::PWR_MANAGED;
    next_q.shutdown = next_q.pwr == rcd_pkg::PWR_OFF;
    // Transmitter: one report in flight, position before status
    if (q.rpt.valid && report_ready) begin
      next_q.rpt.valid = 1'b0;
    end
    if (!q.rpt.valid) begin
      if (q.pos_pend) begin
        next_q.rpt.valid = 1'b1;
        next_q.rpt.bits = pos_bits;
        next_q.pos_pend = 1'b0;
      end else if (q.stat_pend) begin
        next_q.rpt.valid = 1'b1;
        next_q.rpt.bits = stat_bits;
        next_q.stat_pend = 1'b0;
      end
    end
    next_q.rpt.src_id = rcd_pkg::ID_PRIMARY;
    // A request in the launch cycle is kept: the set wins
    if (cmd_ok && page_in.id == rcd_pkg::ID_POSITION) next_q.pos_pend = 1'b1;
    if (cmd_ok && page_in.id == rcd_pkg::ID_STATUS) next_q.stat_pend = 1'b1;
    if (crash_evt) next_q.pos_pend = 1'b1;
    // Read data reflects any write landing in the same cycle
    case (rd_sel)
      rcd_pkg::A_POS_LAT: next_q.hrdata = next_q.lat;
      rcd_pkg::A_POS_LON: next_q.hrdata = 32'(next_q.lon);
      rcd_pkg::A_STAT_A: next_q.hrdata = next_q.stat_a;
      rcd_pkg::A_STAT_B: next_q.hrdata = 32'(next_q.stat_b);
      rcd_pkg::A_STATE: next_q.hrdata = {22'h0, q.pwr, q.fence, q.starter,
                                         q.door, q.pos_pend, q.stat_pend,
                                         q.rpt.valid, q.shutdown};
      default: next_q.hrdata = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.hreadyout <= 1'b1;
      q.starter <= rcd_pkg::STARTER_RST;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata = q.hrdata;
  assign hreadyout = q.hreadyout;
  assign hresp = 1'b0;
  assign report_out = q.rpt;
  assign door_unlock = q.door;
  assign starter_enable = q.starter;
  assign fence_sel = q.fence;
  assign pm_mode = q.pm_mode;
  assign shutdown = q.shutdown;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_door_start: assert property (@(posedge sys_clk) disable iff (reset)
    door_cmd |=> door_unlock) else $error("door unlock not started");
  a_door_length: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(door_unlock) |-> q.door_len >= DOOR_CYCLES)
    else $error("door pulse too short");
  a_starter_off: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_ok && page_in.id == rcd_pkg::ID_STARTER_OFF |=> !starter_enable)
    else $error("starter not disabled");
  a_starter_latch: assert property (@(posedge sys_clk) disable iff (reset)
    !(cmd_ok && (page_in.id == rcd_pkg::ID_STARTER_OFF ||
    page_in.id == rcd_pkg::ID_STARTER_ON)) |=> $stable(starter_enable))
    else $error("starter changed without command");
  a_starter_on: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_ok && page_in.id == rcd_pkg::ID_STARTER_ON |=> starter_enable)
    else $error("starter not enabled");
  a_fence_one: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_ok && page_in.id == rcd_pkg::ID_FENCE_1
    |=> fence_sel == rcd_pkg::FENCE_1MI) else $error("fence one not set");
  a_fence_two: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_ok && page_in.id == rcd_pkg::ID_FENCE_2
    |=> fence_sel == rcd_pkg::FENCE_25MI) else $error("fence two not set");
  a_fence_three: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_ok && page_in.id == rcd_pkg::ID_FENCE_3
    |=> fence_sel == rcd_pkg::FENCE_50MI) else $error("fence three not set");
  a_fence_off: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_ok && page_in.id == rcd_pkg::ID_FENCE_OFF
    |=> fence_sel == rcd_pkg::FENCE_OFF) else $error("fences not off");
  a_bad_ignored: assert property (@(posedge sys_clk) disable iff (reset)
    page_in.valid && !cmd_ok |=> $stable(fence_sel) && $stable(starter_enable))
    else $error("unknown number changed state");
  a_pos_reply: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_ok && page_in.id == rcd_pkg::ID_POSITION && !q.rpt.valid &&
    !q.pos_pend && !q.stat_pend |-> ##2 report_out.valid &&
    report_out.bits[rcd_pkg::REPORT_W-1] == rcd_pkg::MSG_POSITION)
    else $error("position report missing");
  a_stat_reply: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_ok && page_in.id == rcd_pkg::ID_STATUS && !q.rpt.valid &&
    !q.pos_pend && !q.stat_pend && !crash_evt |-> ##2 report_out.valid &&
    report_out.bits[rcd_pkg::REPORT_W-1] == rcd_pkg::MSG_STATUS)
    else $error("status report missing");
  a_report_hold: assert property (@(posedge sys_clk) disable iff (reset)
    report_out.valid && !report_ready |=> report_out.valid &&
    $stable(report_out.bits)) else $error("report dropped before taken");
  a_pm_enter: assert property (@(posedge sys_clk) disable iff (reset)
    q.pwr == rcd_pkg::PWR_FULL && !ignition |=> pm_mode)
    else $error("managed mode not entered");
  a_pm_battery: assert property (@(posedge sys_clk) disable iff (reset)
    pm_mode && battery_low && !ignition |=> !pm_mode && shutdown)
    else $error("managed mode not left on low battery");

endmodule : rcd_dispatcher

// ===== rtl/rcd_pkg.sv
// Constants and types shared by the remote command dispatcher
package rcd_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 10_000_000;
  localparam longint DOOR_PULSE_S = 5;
  localparam longint DOOR_CYCLES = DOOR_PULSE_S * CLK_HZ;
  localparam longint PM_HOLD_H = 72;
  localparam longint PM_CYCLES = PM_HOLD_H * 64'd3600 * CLK_HZ;
  localparam int TMR_W = 42;

  // ----------------------------------------------------------------
  // Identification numbers and report layout
  // ----------------------------------------------------------------
  localparam logic [3:0] ID_PRIMARY = 4'h0;
  localparam logic [3:0] ID_POSITION = 4'h1;
  localparam logic [3:0] ID_DOOR = 4'h2;
  localparam logic [3:0] ID_STARTER_OFF = 4'h3;
  localparam logic [3:0] ID_STARTER_ON = 4'h4;
  localparam logic [3:0] ID_FENCE_1 = 4'h5;
  localparam logic [3:0] ID_FENCE_2 = 4'h6;
  localparam logic [3:0] ID_FENCE_3 = 4'h7;
  localparam logic [3:0] ID_STATUS = 4'h8;
  localparam logic [3:0] ID_FENCE_OFF = 4'h9;
  localparam int REPORT_W = 45;
  localparam int LAT_W = 21;
  localparam int LON_W = 22;
  localparam logic MSG_POSITION = 1'b0;
  localparam logic MSG_STATUS = 1'b1;

  // ----------------------------------------------------------------
  // Register map and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] A_POS_LAT = 8'h00;
  localparam logic [7:0] A_POS_LON = 8'h04;
  localparam logic [7:0] A_STAT_A = 8'h08;
  localparam logic [7:0] A_STAT_B = 8'h0c;
  localparam logic [7:0] A_STATE = 8'h10;
  localparam int FIX_BIT = 31;
  localparam int BATT_LSB = 0;
  localparam int RSSI_LSB = 8;
  localparam int SPEED_LSB = 16;
  localparam int GPS_LSB = 22;
  localparam int VIOL_BIT = 25;
  localparam int AGE_W = 11;
  localparam logic STARTER_RST = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FENCE_OFF, FENCE_1MI, FENCE_25MI, FENCE_50MI
  } rcd_fence_t;

  typedef enum logic [1:0] {PWR_FULL, PWR_MANAGED, PWR_OFF} rcd_power_t;

  typedef struct packed {
    logic valid;
    logic [3:0] id;
  } rcd_page_t;

  typedef struct packed {
    logic valid;
    logic [3:0] src_id;
    logic [REPORT_W-1:0] bits;
  } rcd_report_t;

endpackage : rcd_pkg

// ===== tb/rcd_dispatcher_tb.sv
// Self-checking bench for the remote command dispatcher
`timescale 1ns/1ps
module rcd_dispatcher_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [41:0] DC = 42'd20;
  localparam logic [41:0] PC = 42'd50;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, report_ready, door_unlock, starter_enable;
  logic pm_mode, shutdown;
  logic crash_low = 1'b0;
  logic crash_high = 1'b0;
  logic ignition = 1'b1;
  logic battery_low = 1'b0;
  logic slow = 1'b0;
  logic install = 1'b0;
  rcd_pkg::rcd_page_t tb_pg = '0;
  rcd_pkg::rcd_page_t host_pg, page_in;
  rcd_pkg::rcd_report_t report_out;
  rcd_pkg::rcd_fence_t fence_sel;
  logic [44:0] exp_q[$];
  logic [31:0] lat, lon, sta, stb, q;
  logic [3:0] fid[4] = '{4'h5, 4'h6, 4'h9, 4'h7};
  logic [1:0] fexp[4] = '{2'd1, 2'd2, 2'd0, 2'd3};
  int fails = 0;
  int n_compared = 0;
  int n;

  initial forever #50 sys_clk = ~sys_clk;
  assign page_in = host_pg.valid ? host_pg : tb_pg;

  rcd_dispatcher #(.DOOR_CYCLES(DC), .PM_CYCLES(PC)) dut (
    .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .page_in(page_in), .report_out(report_out),
    .report_ready(report_ready), .crash_low(crash_low),
    .crash_high(crash_high), .ignition(ignition),
    .battery_low(battery_low), .door_unlock(door_unlock),
    .starter_enable(starter_enable), .fence_sel(fence_sel),
    .pm_mode(pm_mode), .shutdown(shutdown));

  rcd_host host (
    .sys_clk(sys_clk), .reset(reset), .report(report_out),
    .report_ready(report_ready), .page(host_pg), .slow(slow),
    .install(install));

  // ----------------------------------------------------------------
  // Checking and reference model
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic give_up;
    fails++;
    $display("mismatch at %0t: wait ran out", $time);
    test_done();
  endtask : give_up

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_report(input rcd_pkg::rcd_report_t r);
    logic [44:0] e;
    n_compared++;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : ~r.bits;
    if ({r.src_id, r.bits} !== {rcd_pkg::ID_PRIMARY, e}) begin
      fails++;
      $display("mismatch at %0t: report %h expected %h", $time, r.bits, e);
    end
  endtask : check_report

  function automatic logic [44:0] pos_exp();
    return {rcd_pkg::MSG_POSITION, lat[20:0], lon[21:0], lat[31]};
  endfunction : pos_exp

  function automatic logic [44:0] stat_exp(input logic [1:0] f,
                                           input logic st);
    logic [2:0] oh;
    oh = (f == 2'd0) ? 3'b000 : 3'b001 << (f - 2'd1);
    return {rcd_pkg::MSG_STATUS, sta[7:0], sta[15:8], sta[21:16],
            stb[10:0], sta[24:22], oh, sta[25], 1'b0, st, 2'b00};
  endfunction : stat_exp

  always @(posedge sys_clk) begin
    if (report_out.valid === 1'b1 && report_ready === 1'b1) begin
      check_report(report_out);
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic bus_edge;
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 20);
    if (hreadyout !== 1'b1) give_up();
  endtask : bus_edge

  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    bus_edge();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    bus_edge();
    r = hrdata;
  endtask : ahb

  task automatic page(input logic [3:0] id);
    @(posedge sys_clk);
    tb_pg <= '{1'b1, id};
    @(posedge sys_clk);
    tb_pg.valid <= 1'b0;
    @(negedge sys_clk);
  endtask : page

  task automatic wait_reports;
    n = 0;
    while (exp_q.size() > 0 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    if (exp_q.size() > 0) give_up();
  endtask : wait_reports

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    n = $urandom(32'h4b46);
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    check_val(32'({hreadyout, hresp, door_unlock, starter_enable,
                   fence_sel}), 32'h24);
    lat = $urandom();
    lon = $urandom();
    sta = $urandom();
    stb = $urandom();
    ahb(rcd_pkg::A_POS_LAT, 1'b1, lat, q);
    ahb(rcd_pkg::A_POS_LON, 1'b1, lon, q);
    ahb(rcd_pkg::A_STAT_A, 1'b1, sta, q);
    ahb(rcd_pkg::A_STAT_B, 1'b1, stb, q);
    ahb(rcd_pkg::A_POS_LAT, 1'b0, 32'h0, q);
    check_val(q, lat);
    ahb(8'h40, 1'b1, 32'hffffffff, q);
    ahb(8'h40, 1'b0, 32'h0, q);
    check_val(q, 32'h0);
    foreach (fid[i]) begin
      page(fid[i]);
      check_val(32'(fence_sel), 32'(fexp[i]));
    end
    page(rcd_pkg::ID_DOOR);
    n = 0;
    while (door_unlock === 1'b1 && n < 100) begin
      n++;
      @(negedge sys_clk);
    end
    check_val(32'(n), 32'(DC));
    for (int i = 0; i < 16; i++) begin
      if (i == 0 || i > 9) page(4'(i));
    end
    repeat (5) @(negedge sys_clk);
    check_val(32'({door_unlock, starter_enable, fence_sel}), 32'h7);
    exp_q.push_back(pos_exp());
    page(rcd_pkg::ID_POSITION);
    wait_reports();
    page(rcd_pkg::ID_STARTER_OFF);
    repeat (10) @(negedge sys_clk);
    check_val(32'(starter_enable), 32'h0);
    ahb(rcd_pkg::A_STATE, 1'b0, 32'h0, q);
    check_val(q, 32'h000000c0);
    // Position then status on consecutive cycles, host stalling
    exp_q.push_back(pos_exp());
    exp_q.push_back(stat_exp(2'd3, 1'b0));
    @(posedge sys_clk);
    slow <= 1'b1;
    tb_pg <= '{1'b1, rcd_pkg::ID_POSITION};
    @(posedge sys_clk);
    tb_pg <= '{1'b1, rcd_pkg::ID_STATUS};
    @(posedge sys_clk);
    tb_pg.valid <= 1'b0;
    wait_reports();
    for (int i = 0; i < 2; i++) begin
      exp_q.push_back(pos_exp());
      @(posedge sys_clk);
      crash_low <= (i == 0);
      crash_high <= (i == 1);
      repeat (10) @(posedge sys_clk);
      crash_low <= 1'b0;
      crash_high <= 1'b0;
      wait_reports();
    end
    page(rcd_pkg::ID_STARTER_ON);
    check_val(32'(starter_enable), 32'h1);
    @(posedge sys_clk);
    slow <= 1'b0;
    install <= 1'b1;
    exp_q.push_back(stat_exp(2'd3, 1'b1));
    page(rcd_pkg::ID_STATUS);
    n = 0;
    while (door_unlock !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    check_val(32'(door_unlock), 32'h1);
    repeat (30) @(posedge sys_clk);
    install <= 1'b0;
    ignition <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check_val(32'({pm_mode, shutdown}), 32'h2);
    n = 0;
    while (shutdown !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    check_val(32'(n), 32'(PC));
    @(posedge sys_clk);
    ignition <= 1'b1;
    repeat (3) @(negedge sys_clk);
    check_val(32'({pm_mode, shutdown}), 32'h0);
    @(posedge sys_clk);
    ignition <= 1'b0;
    repeat (3) @(posedge sys_clk);
    battery_low <= 1'b1;
    repeat (3) @(negedge sys_clk);
    check_val(32'(shutdown), 32'h1);
    @(posedge sys_clk);
    ignition <= 1'b1;
    battery_low <= 1'b0;
    repeat (5) @(negedge sys_clk);
    check_val(32'(exp_q.size()), 32'h0);
    test_done();
  end

  initial begin
    #2_000_000;
    give_up();
  end
endmodule : rcd_dispatcher_tb

// ===== tb/rcd_host.sv
// Behavioural remote host on the far side of the report channel
`timescale 1ns/1ps
module rcd_host (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Reverse channel
  input wire rcd_pkg::rcd_report_t report,
  output logic report_ready,
  // Forward channel
  output rcd_pkg::rcd_page_t page,
  // Test control
  input wire logic slow,
  input wire logic install
);
  logic take;
  logic is_status;

  assign take = report.valid && report_ready;
  assign is_status = (report.bits[44] === rcd_pkg::MSG_STATUS);

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      report_ready <= 1'b0;
      page <= '0;
    end else begin
      // Random stalls keep a report in flight while others queue
      report_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
      // Installation test: a status report is answered by door unlock
      page.valid <= install && take && is_status;
      // Id is scrambled between pages so a stale value cannot pass
      page.id <= (install && take) ? rcd_pkg::ID_DOOR : ~page.id;
    end
  end
endmodule : rcd_host
